// *** cpm_ctrl.sv ***
// Clock source, PLL control, power modes and clock gating of the controller
`timescale 1ns/1ps
// Function
// - Run from RC oscillator after every reset
// - Software selects RC, main or 32k source
// - CPU clock divided from source unless PLL connected
// - PLL input pre-divider from 1 to 256
// - PLL feedback divider from 1 to 32768
// - PLL off and bypassed after reset, power-down
// - Power-up and power-down wake run from RC
// - Main oscillator unusable until wake-up timer expires
// - Idle stops CPU until interrupt or reset
// - Sleep stops clocks, RC output off, 32k on
// - Sleep entry turns off PLL, clears CPU and USB dividers
// - Sleep ends on reset or clockless interrupt
// - Flash stays powered during sleep
// - Sleep wake after 4 RC or 4096 main
// - Power-down also powers off RC and flash
// - Power-down wake: 60 us, then 4 RC
// - Flash blocked until 100 us of RC ticks
// - Per-peripheral clock gate and divider
// - Internal reset holds until oscillator, count, flash ready
module cpm_ctrl #(
  parameter int NPER = 8
) (
  input  wire logic                    MCLK,
  input  wire logic                    RESET_N,
  input  wire logic                    RC_OSC_IN,
  input  wire logic                    MAIN_OSC_IN,
  input  wire logic                    RTC_OSC_IN,
  input  wire logic                    PLL_OSC_IN,
  input  wire logic                    PLL_LOCK_IN,
  input  wire logic                    OSC_RUNNING,
  input  wire logic                    WAKE_IRQ,
  input  wire logic                    IRQ_PENDING,
  input  wire logic                    FLASH_INIT_DONE,
  input  wire logic [1:0]              CLK_SRC_SEL,
  input  wire logic                    MAIN_OSC_EN,
  input  wire logic                    PLL_CTRL_WR,
  input  wire cpm_pkg::cpm_pll_ctrl_t  PLL_CTRL,
  input  wire logic                    PLL_CFG_WR,
  input  wire cpm_pkg::cpm_pll_cfg_t   PLL_CFG,
  input  wire logic                    CPU_DIV_WR,
  input  wire logic [7:0]              CPU_DIV,
  input  wire logic                    USB_DIV_WR,
  input  wire logic [3:0]              USB_DIV,
  input  wire logic                    IDLE_REQ,
  input  wire logic                    SLEEP_REQ,
  input  wire logic                    PDOWN_REQ,
  input  wire logic [NPER-1:0]         PCLK_ON,
  input  wire logic [NPER-1:0][1:0]    PCLK_DIV,
  output logic                         SYS_RESET_N,
  output logic                         CPU_CLK_EN,
  output logic                         USB_CLK_EN,
  output logic [NPER-1:0]              PCLK_EN,
  output logic                         PLL_REF_EN,
  output logic                         PLL_FB_EN,
  output cpm_pkg::cpm_pll_out_t        PLL_OUT,
  output logic                         RC_PWR,
  output logic                         RC_OUT_EN,
  output logic                         MAIN_OSC_PWR,
  output logic                         MAIN_OSC_STABLE,
  output logic                         RTC_OSC_RUN,
  output logic                         FLASH_PWR,
  output logic                         FLASH_READY,
  output cpm_pkg::cpm_src_t            CLK_SRC,
  output cpm_pkg::cpm_mode_t           PWR_MODE
);
  import cpm_pkg::*;

  if (NPER < 1 || NPER > 32) begin : g_chk
    $error("cpm_ctrl: NPER out of range");
  end

  typedef struct packed {
    logic [AI_NUM-1:0][2:0] sy;
    logic [AI_NUM-1:0]      lv;
    cpm_mode_t              mode;
    cpm_src_t               src;
    logic                   pll_pwr;
    logic                   conn_req;
    logic                   conn;
    logic [7:0]             prediv;
    logic [14:0]            mult;
    logic [7:0]             cpu_div;
    logic [3:0]             usb_div;
    logic                   wake_main;
    logic                   pd_wake;
    logic [12:0]            cnt;
    logic [12:0]            main_cnt;
    logic                   main_stable;
    logic [8:0]             flash_cnt;
    logic                   flash_rdy;
    logic                   sys_rst_n;
  } cpm_st_t;

  cpm_st_t st_reg;
  cpm_st_t st_next;

  logic [AI_NUM-1:0] async_in;
  logic [AI_NUM-1:0] rise;
  logic              rc_tk;
  logic              main_tk;
  logic              pll_tk;
  logic              locked;
  logic [2:0]        src_tick;
  cpm_src_t          req_src;
  logic              src_tk;
  logic              base_tk;
  logic              clk_run;
  logic              cpu_run;
  logic              pll_ok;

  assign async_in = {WAKE_IRQ, OSC_RUNNING, PLL_LOCK_IN, PLL_OSC_IN,
                     RTC_OSC_IN, MAIN_OSC_IN, RC_OSC_IN};

  // Edge once second and third stages agree
  for (genvar i = 0; i < AI_NUM; i++) begin : g_edge
    assign rise[i] = (st_reg.sy[i][1] == st_reg.sy[i][2]) && st_reg.sy[i][2]
                     && !st_reg.lv[i];
  end

  assign rc_tk   = rise[AI_RC] && RC_OUT_EN;
  assign main_tk = rise[AI_MAIN] && MAIN_OSC_PWR;
  assign pll_tk  = rise[AI_PLL] && st_reg.pll_pwr;
  assign locked  = st_reg.lv[AI_LOCK];

  assign src_tick = {rise[AI_RTC], main_tk, rc_tk};

  // Main source refused until stable
  always_comb begin
    unique case (CLK_SRC_SEL)
      2'h1:    req_src = st_reg.main_stable ? SRC_MAIN : st_reg.src;
      2'h2:    req_src = SRC_RTC;
      default: req_src = SRC_RC;
    endcase
  end

  assign clk_run = (st_reg.mode == M_RUN) || (st_reg.mode == M_IDLE);
  assign cpu_run = st_reg.mode == M_RUN;
  // Output suppressed while a source change waits for the new edge
  assign src_tk  = (req_src == st_reg.src || !clk_run) ? src_tick[st_reg.src] : 1'b0;
  assign pll_ok  = st_reg.conn_req && st_reg.pll_pwr && locked;
  assign base_tk = st_reg.conn ? pll_tk : src_tk;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < AI_NUM; i++) begin
      st_next.sy[i] = {st_reg.sy[i][1:0], async_in[i]};
      if (st_reg.sy[i][1] == st_reg.sy[i][2]) begin
        st_next.lv[i] = st_reg.sy[i][2];
      end
    end

    // Main oscillator wake-up timer restarts whenever it is off
    if (!MAIN_OSC_PWR) begin
      st_next.main_cnt    = '0;
      st_next.main_stable = 1'b0;
    end else if (main_tk && !st_reg.main_stable) begin
      if (st_reg.main_cnt == MAIN_STABLE_TICKS - 13'h0001) begin
        st_next.main_stable = 1'b1;
      end else begin
        st_next.main_cnt = st_reg.main_cnt + 13'h0001;
      end
    end

    // Flash wake-up timer counts RC ticks
    if (!st_reg.flash_rdy && st_reg.mode != M_PDOWN && st_reg.mode != M_RCSTART
        && rc_tk) begin
      if (st_reg.flash_cnt == FLASH_WAKE_RC - 9'h001) begin
        st_next.flash_rdy = 1'b1;
      end else begin
        st_next.flash_cnt = st_reg.flash_cnt + 9'h001;
      end
    end

    if (clk_run && req_src != st_reg.src && src_tick[req_src]) begin
      st_next.src = req_src;
    end

    // PLL connection changes on a clean edge of the new clock
    if (!st_reg.conn && pll_ok && pll_tk) begin
      st_next.conn = 1'b1;
    end else if (st_reg.conn && !pll_ok && src_tick[st_reg.src]) begin
      st_next.conn = 1'b0;
    end

    if (cpu_run) begin
      if (PLL_CTRL_WR) begin
        st_next.pll_pwr  = PLL_CTRL.enable;
        st_next.conn_req = PLL_CTRL.connect;
      end
      if (PLL_CFG_WR) begin
        st_next.prediv = PLL_CFG.prediv_m1;
        st_next.mult   = PLL_CFG.mult_m1;
      end
      if (CPU_DIV_WR) begin
        st_next.cpu_div = CPU_DIV;
      end
      if (USB_DIV_WR) begin
        st_next.usb_div = USB_DIV;
      end
    end

    unique case (st_reg.mode)
      M_RESET: begin
        if (st_reg.cnt != RST_HOLD_CYC) begin
          st_next.cnt = st_reg.cnt + 13'h0001;
        end else if (st_reg.lv[AI_OSC] && FLASH_INIT_DONE) begin
          st_next.mode      = M_RUN;
          st_next.sys_rst_n = 1'b1;
        end
      end
      M_RUN: begin
        if (PDOWN_REQ || SLEEP_REQ) begin
          st_next.mode      = PDOWN_REQ ? M_PDOWN : M_SLEEP;
          st_next.pll_pwr   = 1'b0;
          st_next.conn_req  = 1'b0;
          st_next.conn      = 1'b0;
          st_next.cpu_div   = '0;
          st_next.usb_div   = '0;
          st_next.wake_main = st_reg.src == SRC_MAIN;
          st_next.pd_wake   = PDOWN_REQ;
          if (PDOWN_REQ) begin
            st_next.src       = SRC_RC;
            st_next.flash_rdy = 1'b0;
            st_next.flash_cnt = '0;
          end
        end else if (IDLE_REQ) begin
          st_next.mode = M_IDLE;
        end
      end
      M_IDLE: begin
        if (IRQ_PENDING || rise[AI_WAKE]) begin
          st_next.mode = M_RUN;
        end
      end
      M_SLEEP: begin
        if (rise[AI_WAKE]) begin
          st_next.mode = M_WAKE;
          st_next.cnt  = '0;
        end
      end
      M_PDOWN: begin
        if (rise[AI_WAKE]) begin
          st_next.mode = M_RCSTART;
          st_next.cnt  = '0;
        end
      end
      M_RCSTART: begin
        if (st_reg.cnt == RC_START_CYC - 13'h0001) begin
          st_next.mode = M_WAKE;
          st_next.cnt  = '0;
        end else begin
          st_next.cnt = st_reg.cnt + 13'h0001;
        end
      end
      M_WAKE: begin
        if (st_reg.pd_wake || !st_reg.wake_main) begin
          if (rc_tk) begin
            st_next.cnt = st_reg.cnt + 13'h0001;
            if (st_reg.cnt == (st_reg.pd_wake ? PD_WAKE_RC : SLEEP_WAKE_RC) - 13'h0001) begin
              st_next.mode = M_RUN;
            end
          end
        end else if (rise[AI_MAIN]) begin
          st_next.cnt = st_reg.cnt + 13'h0001;
          if (st_reg.cnt == SLEEP_WAKE_MAIN - 13'h0001) begin
            st_next.mode = M_RUN;
          end
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg           <= '0;
      st_reg.mode      <= M_RESET;
      st_reg.src       <= SRC_RC;
      st_reg.pll_pwr   <= 1'b0;
      st_reg.prediv    <= PREDIV_RESET;
      st_reg.mult      <= MULT_RESET;
      st_reg.cpu_div   <= CPU_DIV_RESET;
      st_reg.usb_div   <= USB_DIV_RESET;
      st_reg.flash_rdy <= 1'b1;
      st_reg.sys_rst_n <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // PLL reference after pre-divider and feedback after multiplier divider
  cpm_tick_div #(.W(8)) u_prediv (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .clr      (!st_reg.pll_pwr),
    .tick_in  (src_tick[st_reg.src]),
    .div      (st_reg.prediv),
    .tick_out (PLL_REF_EN)
  );

  cpm_tick_div #(.W(15)) u_fbdiv (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .clr      (!st_reg.pll_pwr),
    .tick_in  (pll_tk),
    .div      (st_reg.mult),
    .tick_out (PLL_FB_EN)
  );

  cpm_tick_div #(.W(8)) u_cpudiv (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .clr      (!st_reg.sys_rst_n),
    .tick_in  (base_tk && cpu_run),
    .div      (st_reg.cpu_div),
    .tick_out (CPU_CLK_EN)
  );

  cpm_tick_div #(.W(4)) u_usbdiv (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .clr      (!st_reg.sys_rst_n),
    .tick_in  (pll_tk && st_reg.conn && clk_run),
    .div      (st_reg.usb_div),
    .tick_out (USB_CLK_EN)
  );

  for (genvar p = 0; p < NPER; p++) begin : g_pclk
    cpm_tick_div #(.W(2)) u_pdiv (
      .clk      (MCLK),
      .rst_n    (RESET_N),
      .clr      (!PCLK_ON[p]),
      .tick_in  (base_tk && clk_run && PCLK_ON[p]),
      .div      (PCLK_DIV[p]),
      .tick_out (PCLK_EN[p])
    );
  end

  assign SYS_RESET_N     = st_reg.sys_rst_n;
  assign PLL_OUT         = '{power:     st_reg.pll_pwr,
                             connected: st_reg.conn,
                             prediv_m1: st_reg.prediv,
                             mult_m1:   st_reg.mult};
  assign RC_PWR          = st_reg.mode != M_PDOWN;
  assign RC_OUT_EN       = st_reg.mode != M_PDOWN && st_reg.mode != M_SLEEP;
  assign MAIN_OSC_PWR    = MAIN_OSC_EN && st_reg.mode != M_PDOWN && st_reg.mode != M_SLEEP
                           && st_reg.mode != M_RCSTART;
  assign MAIN_OSC_STABLE = st_reg.main_stable;
  assign RTC_OSC_RUN     = 1'b1;
  assign FLASH_PWR       = st_reg.mode != M_PDOWN;
  assign FLASH_READY     = st_reg.flash_rdy && st_reg.mode != M_PDOWN;
  assign CLK_SRC         = st_reg.src;
  assign PWR_MODE        = st_reg.mode;

endmodule : cpm_ctrl

// *** cpm_ctrl_props.sv ***
// Concurrent checks on the clock and power mode controller ports
`timescale 1ns/1ps
module cpm_ctrl_props (
  input wire logic                  MCLK,
  input wire logic                  RESET_N,
  input wire logic                  FLASH_INIT_DONE,
  input wire logic                  SYS_RESET_N,
  input wire logic                  CPU_CLK_EN,
  input wire cpm_pkg::cpm_pll_out_t PLL_OUT,
  input wire logic                  RC_PWR,
  input wire logic                  RC_OUT_EN,
  input wire logic                  FLASH_PWR,
  input wire logic                  FLASH_READY,
  input wire logic                  MAIN_OSC_STABLE,
  input wire logic                  RTC_OSC_RUN,
  input wire cpm_pkg::cpm_src_t     CLK_SRC,
  input wire cpm_pkg::cpm_mode_t    PWR_MODE
);
  import cpm_pkg::*;
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // Cycles spent waiting for the RC oscillator start
  always_comb cnt_next = (PWR_MODE == M_RCSTART) ? cnt_reg + 13'h0001 : 13'h0000;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) cnt_reg <= 13'h0000;
    else cnt_reg <= cnt_next;
  end
  rst_src_rc_a: assert property (!SYS_RESET_N |-> CLK_SRC == SRC_RC)
    else $error("source not RC in reset");
  rst_pll_off_a: assert property (!SYS_RESET_N |-> !PLL_OUT.power && !PLL_OUT.connected)
    else $error("PLL active in reset");
  rst_hold_a: assert property (!SYS_RESET_N && !FLASH_INIT_DONE |=> !SYS_RESET_N)
    else $error("reset released before flash ready");
  pdown_off_a: assert property (PWR_MODE == M_PDOWN && $past(PWR_MODE) == M_PDOWN
    |-> !RC_PWR && !FLASH_PWR && !FLASH_READY && !PLL_OUT.power)
    else $error("power-down left a unit on");
  sleep_state_a: assert property (PWR_MODE == M_SLEEP && $past(PWR_MODE) == M_SLEEP
    |-> !RC_OUT_EN && RC_PWR && FLASH_PWR && RTC_OSC_RUN && !CPU_CLK_EN
    && !PLL_OUT.power && !PLL_OUT.connected)
    else $error("sleep state wrong");
  idle_cpu_a: assert property (PWR_MODE == M_IDLE && $past(PWR_MODE) == M_IDLE
    |-> !CPU_CLK_EN)
    else $error("cpu clock in idle");
  sleep_exit_a: assert property ($past(PWR_MODE) == M_SLEEP && PWR_MODE != M_SLEEP
    |-> PWR_MODE == M_WAKE)
    else $error("sleep left without wake");
  main_use_a: assert property ($changed(CLK_SRC) && CLK_SRC == SRC_MAIN
    |-> $past(MAIN_OSC_STABLE))
    else $error("main used before stable");
  rc_start_a: assert property ($past(PWR_MODE) == M_RCSTART && PWR_MODE == M_WAKE
    |-> cnt_reg >= RC_START_CYC && cnt_reg <= RC_START_CYC + 13'h0002)
    else $error("RC start wait wrong length");
  flash_block_a: assert property (PWR_MODE == M_RCSTART |-> !FLASH_READY)
    else $error("flash ready during RC start");
  pulse_whole_a: assert property (CPU_CLK_EN |=> !CPU_CLK_EN)
    else $error("cpu clock pulses merged");
endmodule : cpm_ctrl_props

bind cpm_ctrl cpm_ctrl_props u_props (
  .MCLK, .RESET_N, .FLASH_INIT_DONE, .SYS_RESET_N, .CPU_CLK_EN, .PLL_OUT, .RC_PWR,
  .RC_OUT_EN, .FLASH_PWR, .FLASH_READY, .MAIN_OSC_STABLE, .RTC_OSC_RUN, .CLK_SRC,
  .PWR_MODE
);

// *** cpm_osc_model.sv ***
// Oscillator, PLL oscillator and lock model facing the controller
`timescale 1ns/1ps
module cpm_osc_model (
  input  wire logic                  MCLK,
  input  wire logic                  RC_PWR,
  input  wire logic                  MAIN_OSC_PWR,
  input  wire cpm_pkg::cpm_pll_out_t PLL_OUT,
  output logic                       RC_OSC_IN,
  output logic                       MAIN_OSC_IN,
  output logic                       RTC_OSC_IN,
  output logic                       PLL_OSC_IN,
  output logic                       PLL_LOCK_IN,
  output logic                       OSC_RUNNING
);
  import cpm_pkg::*;
  logic [7:0] lock_cnt;
  initial begin
    {RC_OSC_IN, MAIN_OSC_IN, RTC_OSC_IN, PLL_OSC_IN} = 4'h0;
    OSC_RUNNING = 1'b0;
    lock_cnt = 8'h00;
  end
  // Oscillator reports running at a fixed 6007 ns, after the testbench sets flash init done
  initial #6007 OSC_RUNNING = 1'b1;
  // Edges offset from MCLK edges; unpowered oscillators stand low
  initial #7 forever #125 RC_OSC_IN = RC_PWR & ~RC_OSC_IN;
  initial #7 forever #100 MAIN_OSC_IN = MAIN_OSC_PWR & ~MAIN_OSC_IN;
  initial #7 forever #400 RTC_OSC_IN = ~RTC_OSC_IN;
  initial #7 forever #100 PLL_OSC_IN = PLL_OUT.power & ~PLL_OSC_IN;
  // Lock reported only some time after power
  always @(posedge MCLK) begin
    if (!PLL_OUT.power) lock_cnt <= 8'h00;
    else if (lock_cnt != 8'h28) lock_cnt <= lock_cnt + 8'h01;
  end
  assign PLL_LOCK_IN = (lock_cnt == 8'h28);
endmodule : cpm_osc_model

// *** cpm_pkg.sv ***
// Constants and types shared by the clock and power mode controller
package cpm_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int RC_HZ         = 4_000_000;
  localparam int RC_START_NS   = 60_000;
  localparam int FLASH_WAKE_US = 100;

  // Least times round up to whole cycles
  localparam logic [12:0] RC_START_CYC =
    13'((RC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam logic [8:0]  FLASH_WAKE_RC = 9'(FLASH_WAKE_US * (RC_HZ / 1_000_000));

  localparam logic [12:0] SLEEP_WAKE_RC     = 13'h0004;
  localparam logic [12:0] SLEEP_WAKE_MAIN   = 13'h1000;
  localparam logic [12:0] PD_WAKE_RC        = 13'h0004;
  localparam logic [12:0] MAIN_STABLE_TICKS = 13'h1000;
  localparam logic [12:0] RST_HOLD_CYC      = 13'h0040;

  localparam logic [7:0]  PREDIV_RESET = 8'h00;
  localparam logic [14:0] MULT_RESET   = 15'h0000;
  localparam logic [7:0]  CPU_DIV_RESET = 8'h00;
  localparam logic [3:0]  USB_DIV_RESET = 4'h0;

  // Bit positions of the asynchronous input vector
  localparam int AI_RC   = 0;
  localparam int AI_MAIN = 1;
  localparam int AI_RTC  = 2;
  localparam int AI_PLL  = 3;
  localparam int AI_LOCK = 4;
  localparam int AI_OSC  = 5;
  localparam int AI_WAKE = 6;
  localparam int AI_NUM  = 7;

  typedef enum logic [1:0] {SRC_RC, SRC_MAIN, SRC_RTC} cpm_src_t;

  typedef enum logic [2:0] {
    M_RESET, M_RUN, M_IDLE, M_SLEEP, M_PDOWN, M_RCSTART, M_WAKE
  } cpm_mode_t;

  typedef struct packed {
    logic        enable;
    logic        connect;
  } cpm_pll_ctrl_t;

  typedef struct packed {
    logic [7:0]  prediv_m1;
    logic [14:0] mult_m1;
  } cpm_pll_cfg_t;

  typedef struct packed {
    logic        power;
    logic        connected;
    logic [7:0]  prediv_m1;
    logic [14:0] mult_m1;
  } cpm_pll_out_t;

endpackage : cpm_pkg

// *** cpm_tick_div.sv ***
// Programmable divider of a one-cycle tick stream, divide by div+1
`timescale 1ns/1ps
module cpm_tick_div #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div,
  output logic              tick_out
);
  import cpm_pkg::*;

  if (W < 1 || W > 16) begin : g_chk
    $error("cpm_tick_div: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } cpm_div_st_t;

  cpm_div_st_t st_reg;
  cpm_div_st_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.out = 1'b0;
    if (clr) begin
      st_next.cnt = '0;
    end else if (tick_in) begin
      if (st_reg.cnt >= div) begin
        st_next.cnt = '0;
        st_next.out = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.out;

endmodule : cpm_tick_div

// *** tb.sv ***
// Self-checking testbench of the clock and power mode controller
`timescale 1ns/1ps
module tb;
  import cpm_pkg::*;
  logic            MCLK, RESET_N, WAKE_IRQ, IRQ_PENDING, FLASH_INIT_DONE, MAIN_OSC_EN;
  logic            PLL_CTRL_WR, PLL_CFG_WR, CPU_DIV_WR, USB_DIV_WR, IDLE_REQ, SLEEP_REQ;
  logic            PDOWN_REQ, RC_OSC_IN, MAIN_OSC_IN, RTC_OSC_IN, PLL_OSC_IN, PLL_LOCK_IN;
  logic            OSC_RUNNING, SYS_RESET_N, CPU_CLK_EN, USB_CLK_EN, PLL_REF_EN, PLL_FB_EN;
  logic            RC_PWR, RC_OUT_EN, MAIN_OSC_PWR, MAIN_OSC_STABLE, RTC_OSC_RUN;
  logic            FLASH_PWR, FLASH_READY;
  logic [1:0]      CLK_SRC_SEL;
  logic [3:0]      USB_DIV;
  logic [7:0]      CPU_DIV, PCLK_ON, PCLK_EN;
  logic [7:0][1:0] PCLK_DIV;
  logic [3:0]      pv;
  cpm_pll_ctrl_t   PLL_CTRL;
  cpm_pll_cfg_t    PLL_CFG;
  cpm_pll_out_t    PLL_OUT;
  cpm_src_t        CLK_SRC;
  cpm_mode_t       PWR_MODE;
  int              error_cnt = 0;
  int              checked = 0;

  assign pv = {USB_CLK_EN, PLL_FB_EN, PLL_REF_EN, CPU_CLK_EN};
  cpm_ctrl #(.NPER(8)) DUT (.*);
  cpm_osc_model u_osc (.*);

  initial MCLK = 1'b0;
  always #25 MCLK = ~MCLK;

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Cycles between two pulses of the chosen enable
  task automatic gap(input int b, output int n);
    for (int i = 0; i < 3000 && pv[b] !== 1'b1; i++) cyc(1);
    cyc(1);
    for (n = 1; n < 3000 && pv[b] !== 1'b1; n++) cyc(1);
  endtask : gap

  task automatic ctl(input cpm_pll_ctrl_t c);
    PLL_CTRL = c;
    PLL_CTRL_WR = 1'b1;
    cyc(1);
    PLL_CTRL_WR = 1'b0;
  endtask : ctl

  task automatic wake(output int n);
    WAKE_IRQ = 1'b1;
    cyc(4);
    WAKE_IRQ = 1'b0;
    for (n = 4; n < 20000 && PWR_MODE !== M_RUN; n++) cyc(1);
  endtask : wake

  task automatic t_reset;
    cyc(100);
    chk("sys reset held", 1'b0, SYS_RESET_N);
    FLASH_INIT_DONE = 1'b1;
    cyc(4);
    chk("osc wait", 1'b0, SYS_RESET_N);
    for (int i = 0; i < 20 && SYS_RESET_N !== 1'b1; i++) cyc(1);
    chk("sys reset", 1'b1, SYS_RESET_N);
    chk("source", SRC_RC, CLK_SRC);
    chk("pll out", 32'h0000_0000, PLL_OUT);
    chk("mode", M_RUN, PWR_MODE);
  endtask : t_reset

  task automatic t_pll;
    int n;
    CPU_DIV = 8'h01;
    CPU_DIV_WR = 1'b1;
    cyc(1);
    CPU_DIV_WR = 1'b0;
    gap(0, n);
    chk("cpu gap rc", 10, n);
    PLL_CFG = '{prediv_m1: 8'hFF, mult_m1: 15'h0001};
    PLL_CFG_WR = 1'b1;
    cyc(1);
    PLL_CFG_WR = 1'b0;
    ctl(2'h2);
    cyc(1);
    chk("pll early", 32'h017F_8001, PLL_OUT);
    gap(1, n);
    chk("ref gap", 1280, n);
    gap(2, n);
    chk("fb gap", 8, n);
    ctl(2'h3);
    for (int i = 0; i < 50 && PLL_OUT.connected !== 1'b1; i++) cyc(1);
    chk("pll conn", 1'b1, PLL_OUT.connected);
    gap(0, n);
    chk("cpu gap pll", 8, n);
    gap(3, n);
    chk("usb gap", 4, n);
  endtask : t_pll

  task automatic t_idle;
    logic [31:0] c = '0;
    logic [31:0] p0 = '0;
    logic [31:0] p1 = '0;
    IDLE_REQ = 1'b1;
    cyc(1);
    IDLE_REQ = 1'b0;
    cyc(2);
    chk("idle", M_IDLE, PWR_MODE);
    repeat (60) begin
      c += CPU_CLK_EN;
      p0 += PCLK_EN[0];
      p1 += PCLK_EN[1];
      cyc(1);
    end
    chk("idle cpu", 0, c);
    chk("idle pclk", 1, p0 > 0);
    chk("pclk gated", 0, p1);
    IRQ_PENDING = 1'b1;
    cyc(2);
    IRQ_PENDING = 1'b0;
    chk("idle exit", M_RUN, PWR_MODE);
  endtask : t_idle

  task automatic t_sleep;
    int n;
    SLEEP_REQ = 1'b1;
    cyc(1);
    SLEEP_REQ = 1'b0;
    cyc(2);
    chk("sleep pll", 2'h0, {PLL_OUT.power, PLL_OUT.connected});
    chk("rc out", 1'b0, RC_OUT_EN);
    chk("flash pwr", 1'b1, FLASH_PWR);
    IRQ_PENDING = 1'b1;
    cyc(20);
    IRQ_PENDING = 1'b0;
    chk("sleep hold", M_SLEEP, PWR_MODE);
    wake(n);
    chk("sleep wake", 1, n >= 15 && n <= 45);
    gap(0, n);
    chk("cpu div clr", 5, n);
    CPU_DIV = 8'h00;
    CPU_DIV_WR = 1'b1;
    cyc(1);
    CPU_DIV_WR = 1'b0;
  endtask : t_sleep

  task automatic t_pdown;
    int n;
    PDOWN_REQ = 1'b1;
    cyc(1);
    PDOWN_REQ = 1'b0;
    cyc(2);
    chk("pd rc", 1'b0, RC_PWR);
    chk("pd flash", 1'b0, FLASH_READY);
    wake(n);
    chk("pd wake", 1, n >= 1210 && n <= 1260);
    chk("flash blocked", 1'b0, FLASH_READY);
    chk("pd source", SRC_RC, CLK_SRC);
    for (n = 0; n < 3000 && FLASH_READY !== 1'b1; n++) cyc(1);
    chk("flash wake", 1, n >= 1940 && n <= 2020);
  endtask : t_pdown

  task automatic t_src;
    int n;
    CLK_SRC_SEL = 2'h2;
    for (int i = 0; i < 100 && CLK_SRC !== SRC_RTC; i++) cyc(1);
    chk("src rtc", SRC_RTC, CLK_SRC);
    CLK_SRC_SEL = 2'h1;
    cyc(50);
    chk("main early", SRC_RTC, CLK_SRC);
    for (int i = 0; i < 20000 && CLK_SRC !== SRC_MAIN; i++) cyc(1);
    chk("src main", SRC_MAIN, CLK_SRC);
    chk("main stable", 1'b1, MAIN_OSC_STABLE);
    SLEEP_REQ = 1'b1;
    cyc(1);
    SLEEP_REQ = 1'b0;
    cyc(2);
    chk("sleep main off", 1'b0, MAIN_OSC_PWR);
    wake(n);
    chk("main wake", 1, n >= 16384 && n <= 16420);
    chk("main kept", SRC_MAIN, CLK_SRC);
  endtask : t_src

  initial begin
    {RESET_N, WAKE_IRQ, IRQ_PENDING, FLASH_INIT_DONE, PLL_CTRL_WR, PLL_CFG_WR} = '0;
    {CPU_DIV_WR, USB_DIV_WR, IDLE_REQ, SLEEP_REQ, PDOWN_REQ, CLK_SRC_SEL, USB_DIV} = '0;
    {PLL_CTRL, PLL_CFG, CPU_DIV, PCLK_DIV} = '0;
    MAIN_OSC_EN = 1'b1;
    PCLK_ON = 8'h01;
    cyc(12);
    RESET_N = 1'b1;
    t_reset();
    t_pll();
    t_idle();
    t_sleep();
    t_pdown();
    t_src();
    report_and_stop();
  end

  initial begin
    #5_000_000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
